/* File: hw/pvs_pkg.sv */
// package: constants, register map and carrier types of the voice serial port
package pvs_pkg;

    localparam int unsigned PVS_CLK_HZ     = 100_000_000;
    localparam int unsigned PVS_FRAME_HZ   = 8_000;
    localparam int unsigned PVS_BCLK_128K  = 128_000;
    localparam int unsigned PVS_BCLK_256K  = 256_000;
    localparam int unsigned PVS_BCLK_512K  = 512_000;
    localparam int unsigned PVS_LONG_SYNC_BITS = 8;
    localparam int unsigned PVS_NUM_SLOTS  = 4;
    localparam int unsigned PVS_MAX_LINKS  = 3;

    localparam logic [11:0] PVS_ADDR_CFG   = 12'h000;
    localparam logic [11:0] PVS_ADDR_DIV   = 12'h004;
    localparam logic [11:0] PVS_ADDR_STAT  = 12'h008;
    localparam logic [11:0] PVS_ADDR_TX0   = 12'h010;
    localparam logic [11:0] PVS_ADDR_RX0   = 12'h020;

    localparam logic [31:0] PVS_CFG_RST    = 32'h0000_0000;
    localparam logic [31:0] PVS_DIV_RST    = 32'h0020_0186;
    localparam logic [15:0] PVS_SAMPLE_RST = 16'h0000;

    typedef enum logic [1:0] {
        PVS_SYNC_LONG  = 2'h0,
        PVS_SYNC_SHORT = 2'h1,
        PVS_SYNC_GCI   = 2'h2
    } pvs_sync_t;

    typedef enum logic [1:0] {
        PVS_FMT_LIN13 = 2'h0,
        PVS_FMT_LIN16 = 2'h1,
        PVS_FMT_MULAW = 2'h2,
        PVS_FMT_ALAW  = 2'h3
    } pvs_fmt_t;

    typedef enum logic [1:0] {
        PVS_PAD_SIGN  = 2'h0,
        PVS_PAD_ZERO  = 2'h1,
        PVS_PAD_ATTEN = 2'h2
    } pvs_pad_t;

    // audio_port_config_key, one persistent word
    typedef struct packed {
        logic [10:0] rsv;
        logic [1:0]  slow_sel;
        logic        fast_src;
        logic [3:0]  slot_mask;
        logic        hz_early;
        logic        lsb_first;
        logic [2:0]  atten;
        logic [1:0]  pad;
        logic [1:0]  fmt;
        logic        slot16;
        logic [1:0]  sync_fmt;
        logic        master;
        logic        enable;
    } pvs_cfg_t;

    typedef struct packed {
        logic [6:0]  rsv;
        logic [8:0]  frame_bits;
        logic        rsv2;
        logic [14:0] half_div;
    } pvs_div_t;

    typedef struct packed {
        logic clk;
        logic clk_oe;
        logic sync;
        logic sync_oe;
        logic dout;
        logic dout_oe;
    } pvs_pins_t;

endpackage

/* File: hw/pvs_port.sv */
// voice serial port: apb registers, bit clock, framing, slot shifter
`timescale 1ns/10ps
module pvs_port
    import pvs_pkg::*;
#(
    parameter int unsigned CLK_HZ = PVS_CLK_HZ
) (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        pcm_clk_i,
    input  wire logic        pcm_sync_i,
    input  wire logic        pcm_din_i,
    output pvs_pins_t        pcm_o
);

    localparam logic [14:0] HALF_128K = 15'(CLK_HZ / (2 * PVS_BCLK_128K));
    localparam logic [14:0] HALF_256K = 15'(CLK_HZ / (2 * PVS_BCLK_256K));
    localparam logic [14:0] HALF_512K = 15'(CLK_HZ / (2 * PVS_BCLK_512K));
    localparam logic [8:0]  FRAME_128K = 9'(PVS_BCLK_128K / PVS_FRAME_HZ);
    localparam logic [8:0]  FRAME_256K = 9'(PVS_BCLK_256K / PVS_FRAME_HZ);
    localparam logic [8:0]  FRAME_512K = 9'(PVS_BCLK_512K / PVS_FRAME_HZ);
    localparam logic [8:0]  LONG_BITS  = 9'(PVS_LONG_SYNC_BITS);

    // divider must give at least one cycle per half period at 512 khz
    if (CLK_HZ < 2 * PVS_BCLK_512K || CLK_HZ / (2 * PVS_BCLK_128K) > 32767) begin : g_chk
        $error("pvs_port: CLK_HZ out of range");
    end

    // keep at most three of the requested slots, lowest first
    function automatic logic [3:0] limit_links(input logic [3:0] m);
        logic [3:0] r;
        int unsigned n;
        r = 4'h0;
        n = 0;
        for (int i = 0; i < PVS_NUM_SLOTS; i++) begin
            if (m[i] && n < PVS_MAX_LINKS) begin
                r[i] = 1'b1;
                n++;
            end
        end
        return r;
    endfunction

    // slot word, first transmitted bit at [15] when msb first
    function automatic logic [15:0] build_word(input logic [15:0] s, input pvs_cfg_t c);
        logic [15:0] w;
        w = s;
        if (!c.slot16) begin
            // narrow slot: only an 8-bit sample fits, linear keeps its top byte
            w = (c.fmt == PVS_FMT_LIN13) ? {s[12:5], 8'h00}
                : (c.fmt == PVS_FMT_LIN16) ? {s[15:8], 8'h00} : {s[7:0], 8'h00};
        end else if (c.fmt == PVS_FMT_LIN13) begin
            case (c.pad)
                PVS_PAD_SIGN:  w = {{3{s[12]}}, s[12:0]};
                PVS_PAD_ATTEN: w = {s[12:0], c.atten};
                default:       w = {s[12:0], 3'h0};
            endcase
        end else if (c.fmt != PVS_FMT_LIN16) begin
            case (c.pad)
                PVS_PAD_SIGN:  w = {{8{s[7]}}, s[7:0]};
                PVS_PAD_ATTEN: w = {s[7:0], 5'h00, c.atten};
                default:       w = {s[7:0], 8'h00};
            endcase
        end
        return w;
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        return a == PVS_ADDR_CFG || a == PVS_ADDR_DIV || a == PVS_ADDR_STAT
            || ((a[11:4] == PVS_ADDR_TX0[11:4] || a[11:4] == PVS_ADDR_RX0[11:4])
                && a[1:0] == 2'h0);
    endfunction

    pvs_cfg_t    cfg_ff;
    pvs_div_t    div_ff;
    logic [15:0] tx_ff [PVS_NUM_SLOTS];
    logic [15:0] rx_ff [PVS_NUM_SLOTS];
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [2:0]  clk_sy_ff;
    logic [2:0]  sync_sy_ff;
    logic [2:0]  din_sy_ff;
    logic        clk_f_ff;
    logic        sync_f_ff;
    logic        din_f_ff;
    logic [14:0] half_cnt_ff;
    pvs_pins_t   pins_ff;
    logic [8:0]  bit_cnt_ff;
    logic        wrap_pend_ff;
    logic        sync_prev_ff;
    logic [15:0] rx_sh_ff;
    logic [15:0] frames_ff;

    logic        active;
    logic        master;
    logic [1:0]  sync_fmt;
    logic        slot16;
    logic [3:0]  eff_mask;
    logic [14:0] half_tgt;
    logic [8:0]  frame_len;
    logic        tick;
    logic        rise_ev;
    logic        fall_ev;
    logic        sync_now;
    logic        frame_start;
    logic [8:0]  nxt_bit_cnt;
    logic [8:0]  nxt_plus;
    logic [3:0]  nxt_pos;
    logic [4:0]  nxt_slot;
    logic        nxt_slot_on;
    logic [15:0] nxt_word;
    logic [3:0]  cur_pos;
    logic [4:0]  cur_slot;
    logic        cur_slot_on;
    logic        cur_last;
    logic [15:0] nxt_rx_sh;
    logic [31:0] rd_mux;
    logic        acc;

    assign active   = cfg_ff.enable;
    assign master   = cfg_ff.master;
    assign sync_fmt = cfg_ff.sync_fmt;
    // gci carries the two 8-bit b channels in the first two slots
    assign slot16   = (sync_fmt == PVS_SYNC_GCI) ? 1'b0 : cfg_ff.slot16;
    assign eff_mask = limit_links((sync_fmt == PVS_SYNC_GCI) ? 4'h3 : cfg_ff.slot_mask);

    always_comb begin
        half_tgt  = div_ff.half_div;
        frame_len = div_ff.frame_bits;
        if (!cfg_ff.fast_src) begin
            case (cfg_ff.slow_sel)
                2'h0: begin
                    half_tgt  = HALF_128K;
                    frame_len = FRAME_128K;
                end
                2'h1: begin
                    half_tgt  = HALF_256K;
                    frame_len = FRAME_256K;
                end
                default: begin
                    half_tgt  = HALF_512K;
                    frame_len = FRAME_512K;
                end
            endcase
        end
        if (!master) begin
            half_tgt  = div_ff.half_div;
            frame_len = div_ff.frame_bits;
        end
    end

    // pin synchronisers: a change counts once stages two and three agree
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            clk_sy_ff  <= 3'h0;
            sync_sy_ff <= 3'h0;
            din_sy_ff  <= 3'h0;
            clk_f_ff   <= 1'b0;
            sync_f_ff  <= 1'b0;
            din_f_ff   <= 1'b0;
        end else begin
            clk_sy_ff  <= {clk_sy_ff[1:0], pcm_clk_i};
            sync_sy_ff <= {sync_sy_ff[1:0], pcm_sync_i};
            din_sy_ff  <= {din_sy_ff[1:0], pcm_din_i};
            if (clk_sy_ff[1] == clk_sy_ff[2]) begin
                clk_f_ff <= clk_sy_ff[2];
            end
            if (sync_sy_ff[1] == sync_sy_ff[2]) begin
                sync_f_ff <= sync_sy_ff[2];
            end
            if (din_sy_ff[1] == din_sy_ff[2]) begin
                din_f_ff <= din_sy_ff[2];
            end
        end
    end

    // master: divider tick toggles the clock; slave: edges of the filtered pin
    assign tick    = active && master && half_cnt_ff == 15'h0000;
    assign rise_ev = master ? (tick && !pins_ff.clk)
                   : (active && clk_sy_ff[1] == clk_sy_ff[2] && clk_sy_ff[2] && !clk_f_ff);
    assign fall_ev = master ? (tick && pins_ff.clk)
                   : (active && clk_sy_ff[1] == clk_sy_ff[2] && !clk_sy_ff[2] && clk_f_ff);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            half_cnt_ff <= 15'h0000;
        end else if (!active || !master || half_cnt_ff == 15'h0000) begin
            half_cnt_ff <= (half_tgt == 15'h0000) ? 15'h0000 : half_tgt - 15'h0001;
        end else begin
            half_cnt_ff <= half_cnt_ff - 15'h0001;
        end
    end

    // bit position of the bit about to be launched
    assign nxt_plus    = bit_cnt_ff + 9'h001;
    assign nxt_bit_cnt = (wrap_pend_ff || nxt_plus >= frame_len) ? 9'h000 : nxt_plus;
    assign nxt_pos     = slot16 ? nxt_bit_cnt[3:0] : {1'b0, nxt_bit_cnt[2:0]};
    assign nxt_slot    = slot16 ? nxt_bit_cnt[8:4] : {1'b0, nxt_bit_cnt[6:3]};
    assign nxt_slot_on = nxt_slot < 5'(PVS_NUM_SLOTS) && eff_mask[nxt_slot[1:0]];
    assign nxt_word    = build_word(tx_ff[nxt_slot[1:0]], cfg_ff);
    assign cur_pos     = slot16 ? bit_cnt_ff[3:0] : {1'b0, bit_cnt_ff[2:0]};
    assign cur_slot    = slot16 ? bit_cnt_ff[8:4] : {1'b0, bit_cnt_ff[6:3]};
    assign cur_slot_on = cur_slot < 5'(PVS_NUM_SLOTS) && eff_mask[cur_slot[1:0]];
    assign cur_last    = cur_pos == (slot16 ? 4'hF : 4'h7);

    // frame start as seen at the capture edge
    assign sync_now    = master ? pins_ff.sync : sync_f_ff;
    assign frame_start = (sync_fmt == PVS_SYNC_SHORT) ? (!sync_now && sync_prev_ff)
                       : (sync_now && !sync_prev_ff);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            bit_cnt_ff   <= 9'h000;
            wrap_pend_ff <= 1'b0;
            sync_prev_ff <= 1'b0;
            frames_ff    <= 16'h0000;
        end else if (!active) begin
            bit_cnt_ff   <= 9'h000;
            wrap_pend_ff <= 1'b0;
            sync_prev_ff <= 1'b0;
        end else if (rise_ev) begin
            bit_cnt_ff   <= nxt_bit_cnt;
            wrap_pend_ff <= 1'b0;
        end else if (fall_ev) begin
            sync_prev_ff <= sync_now;
            if (frame_start) begin
                frames_ff <= frames_ff + 16'h0001;
                if (!master) begin
                    bit_cnt_ff <= 9'h000;
                end
            end
            // short sync high in the last bit: next launch is bit zero
            if (!master && sync_fmt == PVS_SYNC_SHORT && sync_now) begin
                wrap_pend_ff <= 1'b1;
            end
        end
    end

    // pin drivers: sync and data launched from the rising edge, early dout_oe release on the falling edge
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pins_ff <= '0;
        end else if (!active) begin
            pins_ff <= '0;
        end else begin
            pins_ff.clk_oe  <= master;
            pins_ff.sync_oe <= master;
            if (tick) begin
                pins_ff.clk <= !pins_ff.clk;
            end
            if (rise_ev) begin
                case (sync_fmt)
                    PVS_SYNC_LONG:  pins_ff.sync <= nxt_bit_cnt < LONG_BITS;
                    PVS_SYNC_SHORT: pins_ff.sync <= nxt_bit_cnt == frame_len - 9'h001;
                    default:        pins_ff.sync <= nxt_bit_cnt == 9'h000;
                endcase
                pins_ff.dout_oe <= nxt_slot_on;
                pins_ff.dout    <= cfg_ff.lsb_first
                                 ? nxt_word[(slot16 ? 4'h0 : 4'h8) + nxt_pos]
                                 : nxt_word[4'hF - nxt_pos];
            end else if (fall_ev && cfg_ff.hz_early && cur_last) begin
                pins_ff.dout_oe <= 1'b0;
            end
            if (!master) begin
                pins_ff.sync <= 1'b0;
                pins_ff.clk  <= 1'b0;
            end
        end
    end

    // capture shifter; narrow slots fill the low byte when msb first, the high byte when lsb first
    assign nxt_rx_sh = cfg_ff.lsb_first ? {din_f_ff, rx_sh_ff[15:1]}
                                        : {rx_sh_ff[14:0], din_f_ff};

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_sh_ff <= 16'h0000;
        end else if (fall_ev && cur_slot_on) begin
            rx_sh_ff <= nxt_rx_sh;
        end
    end

    // one sample per enabled slot per frame; raw slot bits, padding kept
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < PVS_NUM_SLOTS; i++) begin
                rx_ff[i] <= PVS_SAMPLE_RST;
            end
        end else if (fall_ev && cur_slot_on && cur_last) begin
            if (slot16 || !cfg_ff.lsb_first) begin
                rx_ff[cur_slot[1:0]] <= slot16 ? nxt_rx_sh : {8'h00, nxt_rx_sh[7:0]};
            end else begin
                rx_ff[cur_slot[1:0]] <= {8'h00, nxt_rx_sh[15:8]};
            end
        end
    end

    // apb slave: one access cycle, reads latched at the setup edge
    assign acc = psel_i && penable_i && pready_ff;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr_i == PVS_ADDR_CFG) begin
            rd_mux = cfg_ff;
        end else if (paddr_i == PVS_ADDR_DIV) begin
            rd_mux = div_ff;
        end else if (paddr_i == PVS_ADDR_STAT) begin
            rd_mux = {frames_ff, 7'h00, bit_cnt_ff};
        end else if (paddr_i[11:4] == PVS_ADDR_TX0[11:4]) begin
            rd_mux = {16'h0000, tx_ff[paddr_i[3:2]]};
        end else if (paddr_i[11:4] == PVS_ADDR_RX0[11:4]) begin
            rd_mux = {16'h0000, rx_ff[paddr_i[3:2]]};
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= psel_i && !penable_i;
            pslverr_ff <= psel_i && !penable_i && !mapped(paddr_i);
            if (psel_i && !penable_i) begin
                prdata_ff <= (pwrite_i || !mapped(paddr_i)) ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // configuration word steers the options; divider word sets fast or slave clock and frame length
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_ff <= PVS_CFG_RST;
            div_ff <= PVS_DIV_RST;
        end else if (acc && pwrite_i) begin
            if (paddr_i == PVS_ADDR_CFG) begin
                cfg_ff     <= pwdata_i;
                cfg_ff.rsv <= '0;
            end
            if (paddr_i == PVS_ADDR_DIV) begin
                div_ff      <= pwdata_i;
                div_ff.rsv  <= '0;
                div_ff.rsv2 <= 1'b0;
            end
        end
    end

    // transmit samples; software may update them mid-frame at its own risk
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < PVS_NUM_SLOTS; i++) begin
                tx_ff[i] <= PVS_SAMPLE_RST;
            end
        end else if (acc && pwrite_i && paddr_i[11:4] == PVS_ADDR_TX0[11:4]
                     && paddr_i[1:0] == 2'h0) begin
            tx_ff[paddr_i[3:2]] <= pwdata_i[15:0];
        end
    end

    assign prdata_o  = prdata_ff;
    assign pready_o  = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign pcm_o     = pins_ff;

endmodule

/* File: hw/pvs_unused_placeholder_none.sv */
// intentionally empty: no further design units
`timescale 1ns/10ps

/* File: testbench/pvs_port_sva.sv */
// checker: apb answers and pin behaviour of the voice serial port
`timescale 1ns/10ps
module pvs_port_sva
    import pvs_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        pcm_clk_i,
    input wire logic        pcm_sync_i,
    input wire logic        pcm_din_i,
    input wire pvs_pins_t   pcm_o
);
    pvs_cfg_t   cfg_ff;
    logic [9:0] age_ff;
    logic [3:0] hi_ff;
    logic       bclk_ff;
    logic       sync_ff;
    logic       mapped;
    logic       settled;
    logic       steady;
    assign mapped  = paddr_i < 12'h030 && paddr_i[1:0] == 2'h0 && paddr_i != 12'h00C;
    assign settled = &age_ff;
    assign steady  = settled && cfg_ff.enable;
    // shadow config; pins judged only 1023 cycles after a cfg or div write, a change may cut a frame short
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_ff <= PVS_CFG_RST;
            age_ff <= 10'h000;
        end else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i[11:3] == 9'h000) begin
            age_ff <= 10'h000;
            if (paddr_i == PVS_ADDR_CFG) begin
                cfg_ff <= pwdata_i;
            end
        end else if (!settled) begin
            age_ff <= age_ff + 10'h001;
        end
    end
    // bit clock rises counted while sync is high
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            bclk_ff <= 1'b0;
            sync_ff <= 1'b0;
            hi_ff   <= 4'h0;
        end else begin
            bclk_ff <= pcm_o.clk;
            sync_ff <= pcm_o.sync;
            if (pcm_o.clk && !bclk_ff) begin
                hi_ff <= !pcm_o.sync ? 4'h0 : (sync_ff ? hi_ff + 4'h1 : 4'h1);
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence apb_setup;
        psel_i && !penable_i;
    endsequence
    sequence apb_answer;
        pready_o ##1 !pready_o;
    endsequence
    chk_apb_answer: assert property (apb_setup |=> apb_answer)
        else $error("apb answer late or long");
    chk_unmapped_err: assert property (psel_i && penable_i && pready_o |-> pslverr_o == !mapped)
        else $error("slave error flag wrong");
    chk_master_pins: assert property (steady && cfg_ff.master |-> pcm_o.clk_oe && pcm_o.sync_oe)
        else $error("master not driving clock and sync");
    chk_slave_pins: assert property (settled && !(cfg_ff.enable && cfg_ff.master)
        |-> !pcm_o.clk_oe && !pcm_o.sync_oe)
        else $error("clock or sync driven as slave");
    chk_idle_quiet: assert property (settled && !cfg_ff.enable |-> pcm_o == '0)
        else $error("pins active while disabled");
    chk_long_width: assert property (steady && cfg_ff.master && cfg_ff.sync_fmt == PVS_SYNC_LONG
        && $fell(pcm_o.sync) |-> hi_ff == 4'h8)
        else $error("long sync width wrong");
    chk_short_width: assert property (steady && cfg_ff.master && cfg_ff.sync_fmt == PVS_SYNC_SHORT
        && $fell(pcm_o.sync) |-> hi_ff == 4'h1)
        else $error("short sync width wrong");
    chk_launch_rise: assert property (steady && cfg_ff.master && pcm_o.dout_oe
        && $past(pcm_o.dout_oe) && $changed(pcm_o.dout) |-> $rose(pcm_o.clk))
        else $error("output changed off a rising edge");
endmodule

bind pvs_port pvs_port_sva chk (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pcm_clk_i(pcm_clk_i),
    .pcm_sync_i(pcm_sync_i), .pcm_din_i(pcm_din_i), .pcm_o(pcm_o));

/* File: testbench/pvs_codec.sv */
// partner model: codec that clocks frames itself or answers a master port
`timescale 1ns/10ps
module pvs_codec
    import pvs_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       slave_i,
    input  wire logic [7:0] byte_i,
    input  wire logic [8:0] bits_i,
    input  wire pvs_pins_t  pins_i,
    output logic            pcm_clk_o,
    output logic            pcm_sync_o,
    output logic            pcm_din_o
);
    int   idx;
    int   b;
    logic mclk_q;
    logic msync_q;
    // own frames; the clock stands still between them
    initial begin
        pcm_clk_o  = 1'b0;
        pcm_sync_o = 1'b0;
        pcm_din_o  = 1'b0;
        mclk_q     = 1'b0;
        msync_q    = 1'b0;
        idx        = 0;
        forever begin
            @(posedge clk_i);
            #3.3;
            for (b = 0; slave_i && b < bits_i; b++) begin
                pcm_sync_o = (b == 0);
                pcm_din_o  = (b < 8) ? byte_i[7 - b] : ~pcm_din_o;
                pcm_clk_o  = 1'b1;
                #40;
                pcm_clk_o  = 1'b0;
                #40;
            end
        end
    end
    // released line toggles, so a stale bit never looks valid
    always @(posedge clk_i) begin
        mclk_q  <= pins_i.clk;
        msync_q <= pins_i.sync;
        if (!slave_i && pins_i.clk && !mclk_q) begin
            idx = (pins_i.sync && !msync_q) ? 0 : idx + 1;
            pcm_din_o <= (idx < 8) ? byte_i[7 - idx] : ~pcm_din_o;
        end
    end
endmodule

/* File: testbench/pvs_port_tb.sv */
// testbench: registers, master frames and slave capture of the voice serial port
`timescale 1ns/10ps
module pvs_port_tb
    import pvs_pkg::*;
;
    logic        clk_i, reset_i, psel, penable, pwrite, pready, pslverr, e;
    logic        pclk, psync, pdin, slave, clk_q, sync_q, psq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  pbyte;
    logic [4:0]  bidx = 5'h00;
    logic [15:0] tx [0:3];
    logic [0:31] cap, cap_oe, last, last_oe;
    pvs_pins_t   pins;
    pvs_cfg_t    cur;
    int          frames = 0;
    int          err_total = 0;
    int          num_checks = 0;
    int          seed;
    logic [31:0] cases [0:7] = '{32'h0004_4A43, 32'h0005_7A63, 32'h0004_CA33, 32'h0004_4A13,
                                 32'h0004_BA93, 32'h0004_4B53, 32'h0007_CAC7, 32'h0004_CA6B};

    pvs_port DUT (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .pcm_clk_i(pclk), .pcm_sync_i(psync),
        .pcm_din_i(pdin), .pcm_o(pins));
    pvs_codec codec (.clk_i(clk_i), .slave_i(slave), .byte_i(pbyte), .bits_i(9'h020),
        .pins_i(pins), .pcm_clk_o(pclk), .pcm_sync_o(psync), .pcm_din_o(pdin));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // frame capture on the port's own clock, mid-bit on its fall
    always @(posedge clk_i) begin
        clk_q  <= pins.clk;
        sync_q <= pins.sync;
        psq    <= psync;
        if (slave && psync && !psq) begin
            frames <= frames + 1;
        end
        if (pins.clk && !clk_q) begin
            if (cur.sync_fmt == PVS_SYNC_SHORT ? sync_q && !pins.sync : pins.sync && !sync_q) begin
                bidx    <= 5'h00;
                last    <= cap;
                last_oe <= cap_oe;
                frames  <= frames + 1;
            end else begin
                bidx <= bidx + 5'h01;
            end
        end
        if (!pins.clk && clk_q) begin
            cap[bidx]    <= pins.dout;
            cap_oe[bidx] <= pins.dout_oe;
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_total++;
            close_out();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_frames(input int k);
        int n;
        int f;
        f = frames + k;
        n = 0;
        while (frames < f && n < 4000 * k) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 4000 * k) begin
            err_total++;
            close_out();
        end
    endtask

    function automatic logic [15:0] exp_word(pvs_cfg_t c, logic [15:0] t);
        logic [2:0] lo;
        lo = (c.pad == PVS_PAD_ZERO) ? 3'h0 : c.atten;
        if (c.fmt == PVS_FMT_LIN16) begin
            return t;
        end else if (!c.slot16) begin
            return {8'h00, t[7:0]};
        end else if (c.fmt == PVS_FMT_LIN13) begin
            return (c.pad == PVS_PAD_SIGN) ? {{3{t[12]}}, t[12:0]} : {t[12:0], lo};
        end
        return (c.pad == PVS_PAD_SIGN) ? {{8{t[7]}}, t[7:0]} : {t[7:0], 5'h00, lo};
    endfunction

    task automatic check_frame();
        int          s;
        int          j;
        int          n;
        int          len;
        logic [15:0] got;
        logic [15:0] w;
        n = 0;
        len = cur.slot16 ? 16 : 8;
        for (s = 0; s < 32 / len; s++) begin
            got = 16'h0000;
            for (j = 0; j < len; j++) begin
                got[len - 1 - j] = last[s * len + j];
            end
            w = exp_word(cur, tx[s]);
            if (cur.lsb_first) begin
                w = {<<{w}};
                w = w >> (16 - len);
            end
            if (cur.slot_mask[s] && n < 3) begin
                n++;
                check(32'(got), 32'(w));
                check(32'(last_oe[s * len]), 32'h1);
                check(32'(last_oe[s * len + len - 1]), 32'(!cur.hz_early));
            end else begin
                check(32'(last_oe[s * len]), 32'h0);
            end
        end
    endtask

    initial begin
        int k;
        int i;
        seed = 32'h074E7298;
        {reset_i, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        {slave, pbyte, cur} = {1'b0, 8'h00, PVS_CFG_RST};
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        apb(1'b0, PVS_ADDR_CFG, 32'h0);
        check(q, PVS_CFG_RST);
        apb(1'b0, PVS_ADDR_DIV, 32'h0);
        check(q, PVS_DIV_RST);
        apb(1'b1, 12'h3FC, 32'hFFFF_FFFF);
        check(32'(e), 32'h1);
        apb(1'b0, 12'h00C, 32'h0);
        check(32'(e), 32'h1);
        apb(1'b1, PVS_ADDR_DIV, 32'h0020_0008);
        $display("test registers done");
        for (k = 0; k < 8; k++) begin
            for (i = 0; i < 4; i++) begin
                tx[i] = 16'($random(seed));
                apb(1'b1, PVS_ADDR_TX0 + 12'(4 * i), {16'h0000, tx[i]});
            end
            pbyte <= 8'($random(seed));
            cur = cases[k];
            apb(1'b1, PVS_ADDR_CFG, cur);
            wait_frames(3);
            check_frame();
            if (k == 0) begin
                apb(1'b0, PVS_ADDR_RX0, 32'h0);
                check(32'(q[7:0]), 32'(pbyte));
            end
            $display("test master case %0d done", k);
        end
        slave <= 1'b1;
        cur = 32'h0004_4A41;
        apb(1'b1, PVS_ADDR_CFG, cur);
        wait_frames(5);
        apb(1'b0, PVS_ADDR_RX0, 32'h0);
        check(32'(q[7:0]), 32'(pbyte));
        check(32'(pins.clk_oe), 32'h0);
        $display("test slave done");
        slave <= 1'b0;
        apb(1'b1, PVS_ADDR_CFG, 32'h0);
        repeat (1100) @(posedge clk_i);
        check(32'(pins), 32'h0);
        $display("test disable done");
        close_out();
    end
endmodule
